// *** pcg_pkg.sv ***
// package: register map, field layout and reset values of the clock gating
package pcg_pkg;
  localparam int PCG_AW = 12;
  localparam int PCG_DW = 32;
  localparam int PCG_NUNIT = 64;
  localparam int PCG_UW = 6;

  localparam logic [11:0] PCG_OFF_RUN0 = 12'h100;
  localparam logic [11:0] PCG_OFF_RUN1 = 12'h104;
  localparam logic [11:0] PCG_OFF_SLP0 = 12'h110;
  localparam logic [11:0] PCG_OFF_SLP1 = 12'h114;
  localparam logic [11:0] PCG_OFF_DSL0 = 12'h120;
  localparam logic [11:0] PCG_OFF_DSL1 = 12'h124;
  localparam logic [11:0] PCG_OFF_CFG = 12'h060;
  localparam logic [11:0] PCG_OFF_ISTAT = 12'h200;
  localparam logic [11:0] PCG_OFF_IMASK = 12'h204;

  // writable bits; everything else reads as zero
  localparam logic [31:0] PCG_GATE0_MASK = 32'h0000_0048;
  localparam logic [31:0] PCG_GATE1_MASK = 32'h0007_5037;
  localparam logic [31:0] PCG_GATE0_RST = 32'h0000_0040;
  localparam logic [31:0] PCG_GATE1_RST = 32'h0000_0000;
  localparam logic [31:0] PCG_ZERO = 32'h0000_0000;

  localparam int PCG_WDT_BIT = 3;
  localparam int PCG_HIB_BIT = 6;
  localparam int PCG_TMR2_BIT = 18;
  localparam int PCG_AUTO_BIT = 27;

  localparam int PCG_IRQ_W = 2;
  localparam int PCG_IRQ_FAULT = 0;
  localparam int PCG_IRQ_MODE = 1;
  localparam logic [1:0] PCG_IRQ_RST = 2'h0;

  typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP} pcg_mode_t;
endpackage : pcg_pkg

// *** pcg_gate_sel.sv ***
// per-unit clock enable: picks the gating set of the mode while auto_gate is set, else the run set
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_sel
  import pcg_pkg::*;
#(
  parameter int NUNIT = PCG_NUNIT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic auto_gate,
  input wire pcg_mode_t mode,
  input wire logic [NUNIT-1:0] run_gate,
  input wire logic [NUNIT-1:0] slp_gate,
  input wire logic [NUNIT-1:0] dsl_gate,
  output logic [NUNIT-1:0] en_q
);
  logic [NUNIT-1:0] en_d;

  genvar i;
  generate
    for (i = 0; i < NUNIT; i++) begin : g_unit
      always_comb begin
        unique case (mode)
          PCG_SLEEP: begin
            en_d[i] = auto_gate ? slp_gate[i] : run_gate[i];
          end
          PCG_DEEP: begin
            en_d[i] = auto_gate ? dsl_gate[i] : run_gate[i];
          end
          PCG_RUN: en_d[i] = run_gate[i];
          // unused code: fall back to the run set rather than hold a latch
          default: en_d[i] = run_gate[i];
        endcase
      end
    end
  endgenerate

  // enables leave a flop so the gating cells see a glitch-free level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= '0;
    end else begin
      en_q <= en_d;
    end
  end

  a_sel_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!auto_gate || mode == PCG_RUN) |=> en_q == $past(run_gate))
    else $error("run set not applied");
  a_sel_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (auto_gate && mode == PCG_SLEEP) |=> en_q == $past(slp_gate))
    else $error("sleep set not applied");
  a_sel_deep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (auto_gate && mode == PCG_DEEP) |=> en_q == $past(dsl_gate))
    else $error("deep-sleep set not applied");
endmodule : pcg_gate_sel
`default_nettype wire

// *** pcg_fault_chk.sv ***
// answers each peripheral access: completes it or flags a bus fault
`timescale 1ns/1ps
`default_nettype none
module pcg_fault_chk
  import pcg_pkg::*;
#(
  parameter int NUNIT = PCG_NUNIT,
  parameter int UW = PCG_UW
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire logic [UW-1:0] acc_unit,
  input wire logic [NUNIT-1:0] clk_en,
  output logic acc_ready_q,
  output logic acc_fault_q
);
  logic acc_ready_d;
  logic acc_fault_d;

  always_comb begin
    acc_ready_d = acc_valid && clk_en[acc_unit];
    acc_fault_d = acc_valid && !clk_en[acc_unit];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ready_q <= 1'b0;
      acc_fault_q <= 1'b0;
    end else begin
      acc_ready_q <= acc_ready_d;
      acc_fault_q <= acc_fault_d;
    end
  end

  a_fault_gated: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (acc_valid && !clk_en[acc_unit]) |=> acc_fault_q && !acc_ready_q)
    else $error("access to gated unit did not fault");
  a_ok_clocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc_valid && clk_en[acc_unit]) |=> acc_ready_q && !acc_fault_q)
    else $error("access to clocked unit faulted");
endmodule : pcg_fault_chk
`default_nettype wire

// *** pcg_top.sv ***
// peripheral clock gating: apb registers, mode select, fault and interrupt
`timescale 1ns/1ps
`default_nettype none
module pcg_top
  import pcg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PCG_AW-1:0] paddr,
  input wire logic [PCG_DW-1:0] pwdata,
  output logic [PCG_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic acc_valid,
  input wire logic [PCG_UW-1:0] acc_unit,
  output logic acc_ready,
  output logic acc_fault,
  output logic [PCG_NUNIT-1:0] periph_clk_en,
  output logic hibernate_clock_enable,
  output logic watchdog_clock_enable,
  output logic gp_timer_two_clock_enable,
  output logic irq
);
  localparam int HALF = PCG_NUNIT / 2;

  // register state
  logic [PCG_DW-1:0] run0_q, run0_d;
  logic [PCG_DW-1:0] run1_q, run1_d;
  logic [PCG_DW-1:0] slp0_q, slp0_d;
  logic [PCG_DW-1:0] slp1_q, slp1_d;
  logic [PCG_DW-1:0] dsl0_q, dsl0_d;
  logic [PCG_DW-1:0] dsl1_q, dsl1_d;
  logic auto_q, auto_d;
  logic [PCG_IRQ_W-1:0] stat_q, stat_d;
  logic [PCG_IRQ_W-1:0] mask_q, mask_d;

  // bus answer state
  logic [PCG_DW-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;

  // power mode state
  pcg_mode_t mode_q, mode_d;

  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [PCG_DW-1:0] rd_mux;
  logic [PCG_IRQ_W-1:0] events;
  logic [PCG_NUNIT-1:0] clk_en;
  logic fault_q;
  logic ready_q;

  // ---------------------------------------------------------------- apb
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;

  always_comb begin
    hit = 1'b1;
    rd_mux = PCG_ZERO;
    unique case (paddr)
      PCG_OFF_RUN0: rd_mux = run0_q;
      PCG_OFF_RUN1: rd_mux = run1_q;
      PCG_OFF_SLP0: rd_mux = slp0_q;
      PCG_OFF_SLP1: rd_mux = slp1_q;
      PCG_OFF_DSL0: rd_mux = dsl0_q;
      PCG_OFF_DSL1: rd_mux = dsl1_q;
      PCG_OFF_CFG: rd_mux[PCG_AUTO_BIT] = auto_q;
      PCG_OFF_ISTAT: rd_mux[PCG_IRQ_W-1:0] = stat_q;
      PCG_OFF_IMASK: rd_mux[PCG_IRQ_W-1:0] = mask_q;
      default: hit = 1'b0;
    endcase
  end

  // no wait state: data and status are sampled in setup, ready in access
  always_comb begin
    pready_d = setup;
    pslverr_d = setup && !hit;
    prdata_d = setup ? rd_mux : prdata_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= PCG_ZERO;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------------------------------------------------- gate sets
  // writes land only on the documented bits; reserved bits stay zero
  always_comb begin
    run0_d = run0_q;
    run1_d = run1_q;
    slp0_d = slp0_q;
    slp1_d = slp1_q;
    dsl0_d = dsl0_q;
    dsl1_d = dsl1_q;
    auto_d = auto_q;
    mask_d = mask_q;
    if (wr_en) begin
      unique case (paddr)
        PCG_OFF_RUN0: run0_d = pwdata & PCG_GATE0_MASK;
        PCG_OFF_RUN1: run1_d = pwdata & PCG_GATE1_MASK;
        PCG_OFF_SLP0: slp0_d = pwdata & PCG_GATE0_MASK;
        PCG_OFF_SLP1: slp1_d = pwdata & PCG_GATE1_MASK;
        PCG_OFF_DSL0: dsl0_d = pwdata & PCG_GATE0_MASK;
        PCG_OFF_DSL1: dsl1_d = pwdata & PCG_GATE1_MASK;
        PCG_OFF_CFG: auto_d = pwdata[PCG_AUTO_BIT];
        PCG_OFF_IMASK: mask_d = pwdata[PCG_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // reg 0 copies keep the printed 0x40; hibernation is clocked out of reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run0_q <= PCG_GATE0_RST;
      run1_q <= PCG_GATE1_RST;
      slp0_q <= PCG_GATE0_RST;
      slp1_q <= PCG_GATE1_RST;
      dsl0_q <= PCG_GATE0_RST;
      dsl1_q <= PCG_GATE1_RST;
      auto_q <= 1'b0;
      mask_q <= PCG_IRQ_RST;
    end else begin
      run0_q <= run0_d;
      run1_q <= run1_d;
      slp0_q <= slp0_d;
      slp1_q <= slp1_d;
      dsl0_q <= dsl0_d;
      dsl1_q <= dsl1_d;
      auto_q <= auto_d;
      mask_q <= mask_d;
    end
  end

  // --------------------------------------------------------- power mode
  // requests come from the power controller on this clock: no sync needed
  always_comb begin
    if (deep_sleep_req) begin
      mode_d = PCG_DEEP;
    end else if (sleep_req) begin
      mode_d = PCG_SLEEP;
    end else begin
      mode_d = PCG_RUN;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= PCG_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  pcg_gate_sel #(
    .NUNIT(PCG_NUNIT)
  ) u_gate_sel (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .auto_gate(auto_q),
    .mode(mode_q),
    .run_gate({run1_q, run0_q}),
    .slp_gate({slp1_q, slp0_q}),
    .dsl_gate({dsl1_q, dsl0_q}),
    .en_q(clk_en)
  );

  pcg_fault_chk #(
    .NUNIT(PCG_NUNIT),
    .UW(PCG_UW)
  ) u_fault_chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .acc_valid(acc_valid),
    .acc_unit(acc_unit),
    .clk_en(clk_en),
    .acc_ready_q(ready_q),
    .acc_fault_q(fault_q)
  );

  // --------------------------------------------------------- interrupts
  always_comb begin
    events = '0;
    events[PCG_IRQ_FAULT] = fault_q;
    events[PCG_IRQ_MODE] = (mode_q != mode_d);
  end

  // a read clears only what it returned, and a new event wins the clear
  always_comb begin
    stat_d = stat_q;
    if (rd_en && paddr == PCG_OFF_ISTAT) begin
      stat_d = stat_q & ~prdata_q[PCG_IRQ_W-1:0];
    end
    stat_d = stat_d | events;
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= PCG_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end

  // ------------------------------------------------------------ outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign acc_ready = ready_q;
  assign acc_fault = fault_q;
  assign periph_clk_en = clk_en;
  assign hibernate_clock_enable = clk_en[PCG_HIB_BIT];
  assign watchdog_clock_enable = clk_en[PCG_WDT_BIT];
  assign gp_timer_two_clock_enable = clk_en[HALF + PCG_TMR2_BIT];

  // --------------------------------------------------------- assertions
  sequence s_apb_wr(logic [PCG_AW-1:0] a);
    psel && penable && pready_q && pwrite && paddr == a;
  endsequence

  sequence s_deep_auto;
    auto_q && mode_q == PCG_DEEP;
  endsequence

  sequence s_run_set;
    !auto_q || mode_q == PCG_RUN;
  endsequence

  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (dsl0_q & ~PCG_GATE0_MASK) == PCG_ZERO)
    else $error("reserved bit of deep-sleep gate 0 set");

  a_run1_write: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    s_apb_wr(PCG_OFF_RUN1) |=> run1_q == ($past(pwdata) & PCG_GATE1_MASK))
    else $error("run gate 1 write not taken");

  a_hib_deep_off: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (s_deep_auto and !dsl0_q[PCG_HIB_BIT]) |=> !hibernate_clock_enable)
    else $error("hibernation clocked while its deep-sleep bit is clear");

  a_hib_deep_on: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (s_deep_auto and dsl0_q[PCG_HIB_BIT]) |=> hibernate_clock_enable)
    else $error("hibernation unclocked while its deep-sleep bit is set");

  a_wdt_deep_on: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (s_deep_auto and dsl0_q[PCG_WDT_BIT]) |=> watchdog_clock_enable)
    else $error("watchdog unclocked while its deep-sleep bit is set");

  a_wdt_deep_off: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (s_deep_auto and !dsl0_q[PCG_WDT_BIT]) |=> !watchdog_clock_enable)
    else $error("watchdog clocked while its deep-sleep bit is clear");

  a_tmr2_on: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (s_run_set and run1_q[PCG_TMR2_BIT]) |=> gp_timer_two_clock_enable)
    else $error("timer two unclocked while its run bit is set");

  a_tmr2_off: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (s_run_set and !run1_q[PCG_TMR2_BIT]) |=> !gp_timer_two_clock_enable)
    else $error("timer two clocked while its run bit is clear");

  a_dsl0_write: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    s_apb_wr(PCG_OFF_DSL0) |=> dsl0_q == ($past(pwdata) & PCG_GATE0_MASK))
    else $error("deep-sleep gate 0 write not taken");

  a_slp1_write: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    s_apb_wr(PCG_OFF_SLP1) |=> slp1_q == ($past(pwdata) & PCG_GATE1_MASK))
    else $error("sleep gate 1 write not taken");

  a_cfg_write: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (s_apb_wr(PCG_OFF_CFG) and pwdata[PCG_AUTO_BIT]) |=> auto_q)
    else $error("automatic gating not enabled by write");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|(stat_q & mask_q)) |=> irq)
    else $error("interrupt not raised for pending unmasked bit");

  a_irq_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(|(stat_q & mask_q)) |=> !irq)
    else $error("interrupt raised with nothing pending");

  a_apb_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    setup |=> pready ##1 !pready)
    else $error("apb answer not exactly one cycle after setup");

  a_apb_slverr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (setup && !hit) |=> pready && pslverr)
    else $error("unmapped access not answered with an error");

  a_fault_sticky: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    fault_q |=> stat_q[PCG_IRQ_FAULT])
    else $error("fault event lost");

  a_mode_event: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (mode_q != mode_d) |=> stat_q[PCG_IRQ_MODE])
    else $error("power mode change event lost");

  a_rst_run1: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> run1_q == PCG_GATE1_RST)
    else $error("run gate 1 not zero after reset");

  a_rst_dsl0: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> dsl0_q == PCG_GATE0_RST)
    else $error("deep-sleep gate 0 not at its reset value");

  a_gate_layout: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (((run0_q | slp0_q) & ~PCG_GATE0_MASK) == PCG_ZERO) &&
    (((run1_q | slp1_q | dsl1_q) & ~PCG_GATE1_MASK) == PCG_ZERO))
    else $error("reserved bit set in a gate copy");
endmodule : pcg_top
`default_nettype wire

// *** tb_top.sv ***
// testbench: apb register, gating mode, fault and interrupt checks
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pcg_pkg::*;
();
  logic ref_clk, rst_n, psel, penable, pwrite;
  logic sleep_req, deep_sleep_req, acc_valid, acc_ready, acc_fault;
  logic pready, pslverr, irq, hib_en, wdt_en, tmr2_en;
  logic [PCG_AW-1:0] paddr;
  logic [PCG_DW-1:0] pwdata, prdata, rd;
  logic [PCG_UW-1:0] acc_unit;
  logic [PCG_NUNIT-1:0] periph_clk_en;
  logic err;
  int n_fail, checks_done, cyc;

  pcg_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .acc_valid(acc_valid), .acc_unit(acc_unit), .acc_ready(acc_ready),
    .acc_fault(acc_fault), .periph_clk_en(periph_clk_en),
    .hibernate_clock_enable(hib_en), .watchdog_clock_enable(wdt_en),
    .gp_timer_two_clock_enable(tmr2_en), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // a hung handshake would otherwise stall the run forever
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no own limit: only the bench timeout ends this wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, e);
  endtask : rchk

  task acc(input logic [5:0] u, input logic rdy, input logic flt);
    @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc_unit <= u;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    @(posedge ref_clk);
    chk("acc_ready", acc_ready, rdy);
    chk("acc_fault", acc_fault, flt);
  endtask : acc

  // enables settle two edges after a change; four leaves margin
  task en_chk(input logic [63:0] e);
    repeat (4) @(posedge ref_clk);
    chk("periph_clk_en", periph_clk_en, e);
  endtask : en_chk

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, sleep_req, deep_sleep_req, acc_valid} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    acc_unit = 6'h00;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    en_chk(64'h0000_0000_0000_0040);
    rchk("run1", PCG_OFF_RUN1, 32'h0000_0000);
    rchk("dsl0", PCG_OFF_DSL0, 32'h0000_0040);
    rchk("run0", PCG_OFF_RUN0, PCG_GATE0_RST);
    rchk("slp1", PCG_OFF_SLP1, PCG_GATE1_RST);
    chk("irq", irq, 1'b0);
    $display("test reset done");

    apb(1'b1, PCG_OFF_DSL0, 32'hFFFF_FFFF);
    rchk("dsl0", PCG_OFF_DSL0, 32'h0000_0048);
    apb(1'b1, PCG_OFF_DSL0, 32'h0000_0000);
    rchk("dsl0", PCG_OFF_DSL0, 32'h0000_0000);
    apb(1'b1, PCG_OFF_DSL0, 32'h0000_0048);
    apb(1'b1, PCG_OFF_RUN1, 32'hFFFF_FFFF);
    rchk("run1", PCG_OFF_RUN1, PCG_GATE1_MASK);
    apb(1'b1, 12'h3FC, 32'hFFFF_FFFF);
    chk("pslverr", err, 1'b1);
    rchk("unmapped", 12'h3FC, 32'h0000_0000);
    $display("test registers done");

    apb(1'b1, PCG_OFF_RUN0, 32'h0000_0008);
    apb(1'b1, PCG_OFF_RUN1, 32'h0004_0000);
    en_chk(64'h0004_0000_0000_0008);
    chk("hib", hib_en, 1'b0);
    chk("wdt", wdt_en, 1'b1);
    chk("tmr2", tmr2_en, 1'b1);
    acc(6'd50, 1'b1, 1'b0);
    acc(6'd6, 1'b0, 1'b1);
    apb(1'b1, PCG_OFF_RUN1, 32'h0000_0000);
    acc(6'd50, 1'b0, 1'b1);
    $display("test gating done");

    apb(1'b1, PCG_OFF_IMASK, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    chk("irq", irq, 1'b1);
    rchk("istat", PCG_OFF_ISTAT, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    chk("irq", irq, 1'b0);
    apb(1'b1, PCG_OFF_IMASK, 32'h0000_0000);
    acc(6'd51, 1'b0, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk("irq", irq, 1'b0);
    rchk("istat", PCG_OFF_ISTAT, 32'h0000_0001);
    rchk("istat", PCG_OFF_ISTAT, 32'h0000_0000);
    $display("test interrupt done");

    apb(1'b1, PCG_OFF_RUN1, 32'h0004_0000);
    deep_sleep_req <= 1'b1;
    en_chk(64'h0004_0000_0000_0008);
    sleep_req <= 1'b1;
    deep_sleep_req <= 1'b0;
    en_chk(64'h0004_0000_0000_0008);
    apb(1'b1, PCG_OFF_CFG, 32'h0800_0000);
    en_chk(64'h0000_0000_0000_0040);
    apb(1'b1, PCG_OFF_SLP1, 32'h0004_0000);
    en_chk(64'h0004_0000_0000_0040);
    deep_sleep_req <= 1'b1;
    en_chk(64'h0000_0000_0000_0048);
    acc(6'd50, 1'b0, 1'b1);
    apb(1'b1, PCG_OFF_DSL0, 32'h0000_0000);
    en_chk(64'h0000_0000_0000_0000);
    chk("hib", hib_en, 1'b0);
    chk("wdt", wdt_en, 1'b0);
    sleep_req <= 1'b0;
    deep_sleep_req <= 1'b0;
    en_chk(64'h0004_0000_0000_0008);
    apb(1'b0, PCG_OFF_ISTAT, 32'h0000_0000);
    chk("istat_mode", rd[1], 1'b1);
    rchk("cfg", PCG_OFF_CFG, 32'h0800_0000);
    $display("test modes done");

    // reset again in mid-run: the enables, cfg, dsl0, slp1 and run1 must fall back to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    en_chk(64'h0000_0000_0000_0040);
    rchk("cfg", PCG_OFF_CFG, 32'h0000_0000);
    rchk("dsl0", PCG_OFF_DSL0, 32'h0000_0040);
    rchk("slp1", PCG_OFF_SLP1, 32'h0000_0000);
    rchk("run1", PCG_OFF_RUN1, 32'h0000_0000);
    chk("irq", irq, 1'b0);
    $display("test reset again done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
